// ===== rtl/fcr_fetch_regs.sv
/*
 * Fetch unit control register bank: translation buffer fill and
 * invalidate, fault address format views, profiled PC, exception address
 * capture and the combined interrupt enable / current mode register.
 * Assumes every register write presented by the pipeline has retired,
 * and that event inputs are single-cycle pulses synchronous to clk_sys.
 */
//
// Notes on behaviour
// - Data fault format reads page entry address from fault address and data control.
// - Tag write only loads a holding register; array is untouched.
// - Entry write stores held tag plus written page contents into one entry.
// - Round-robin fill pointer advances per fill; first fill after reset hits entry 0.
// - Invalidate-process write drops every entry whose global bit is clear.
// - Invalidate-all write drops every entry; cache flush needs its own write.
// - Single invalidate matches page bits 47:13 and context space number 46:39.
// - Single invalidate also drops global entries with matching page, any space.
// - Single invalidate never flushes the instruction cache.
// - Profiled PC: address in 63:2, bit 1 zero, bit 0 firmware flag.
// - Every exception or interrupt updates exception address; bit 0 firmware flag.
// - Fault or synchronous trap captures the PC of the faulting instruction.
// - Interrupt captures the PC of the next instruction that would run.
// - Instruction fault format uses exception address and instruction control bits.
// - Enable-and-mode register selected when index bits 7:2 equal 000010.
// - Index bit 1 enables enable-field write, bit 0 enables mode-field write.
// - Reading enable-and-mode returns both fields together.
// - Enable field holds external, serial, corrected-error, counter and software enables.
// - Trap enable bit 13 passes only trap requests enabled per mode.
// - Wide select picks 48-bit format when set, 43-bit when clear; format views use 32-bit format whenever bit 2 is set.
// - Data translation miss or fault captures the effective address.
`timescale 1ns/1ns
module fcr_fetch_regs
	import fcr_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire fcr_req_s         wr_req,
	input  wire fcr_req_s         rd_req,
	output logic [63:0]           rd_data_ff,
	output logic                  rd_ack_ff,
	input  wire logic             dfault_valid,
	input  wire logic [63:0]      dfault_addr,
	input  wire logic             exc_valid,
	input  wire logic             exc_is_interrupt,
	input  wire logic [63:0]      exc_fault_pc,
	input  wire logic [63:0]      exc_next_pc,
	input  wire logic             exc_in_firmware,
	input  wire logic             prof_valid,
	input  wire logic [63:0]      prof_pc,
	input  wire logic             prof_in_firmware,
	input  wire logic             chk_valid,
	input  wire logic [63:0]      chk_addr,
	output logic                  chk_violation_ff,
	input  wire logic [VPN_W-1:0] lk_vpn,
	output logic                  lk_hit_ff,
	output logic [PFN_W-1:0]      lk_pfn_ff,
	input  wire logic [3:0]       per_mode_trap_enables,
	output logic [3:0]            async_trap_enables,
	output logic [25:0]           interrupt_enables,
	output logic [1:0]            current_privilege_field,
	output logic                  big_endian_mode,
	output logic                  icache_flush_all,
	output logic                  icache_flush_nonglobal
);

	// ****************************************
	// Storage
	// ****************************************
	logic [63:0]      data_address_control_ff;
	logic [63:0]      instruction_unit_control_ff;
	logic [63:0]      process_context_ff;
	logic [63:0]      faulting_data_address_ff;
	logic [63:0]      exception_return_address_ff;
	logic [63:0]      profiled_instruction_pc_ff;
	logic [VPN_W-1:0] tag_hold_ff;
	logic [PTR_W-1:0] fill_ptr_ff;
	logic [25:0]      ier_ff;
	logic [1:0]       cm_ff;
	logic             flush_all_ff;
	logic             flush_ng_ff;

	// ****************************************
	// Write decode
	// ****************************************
	logic          wr_tag;
	logic          wr_entry;
	logic          wr_inv_proc;
	logic          wr_inv_all;
	logic          wr_inv_single;
	logic          wr_interrupt_enable_and_mode;
	logic [ENTRIES-1:0] fill_vec;
	logic [ENTRIES-1:0] hit_vec;
	fcr_entry_s    contents_vec [ENTRIES];
	fcr_entry_s    fill_data;

	always_comb begin
		wr_tag        = wr_req.valid && wr_req.index == IDX_TAG_HOLD;
		wr_entry      = wr_req.valid && wr_req.index == IDX_ENTRY_WR;
		wr_inv_proc   = wr_req.valid && wr_req.index == IDX_INV_PROC;
		wr_inv_all    = wr_req.valid && wr_req.index == IDX_INV_ALL;
		wr_inv_single = wr_req.valid && wr_req.index == IDX_INV_SINGLE;
		wr_interrupt_enable_and_mode     = wr_req.valid && wr_req.index[7:2] == SEL_INTERRUPT_ENABLE_AND_MODE;
	end

	// ****************************************
	// Page entry address formatting
	// ****************************************
	function automatic logic [63:0] fmt_pte_addr(input logic [63:0] ctl,
			input logic [63:0] va);
		logic [63:0] r;
		r = '0;
		if (ctl[CTL_F32_BIT]) begin
			r = {32'h0, ctl[31:30], 8'h0, va[31:13], 3'h0};
		end else if (ctl[CTL_WIDE_BIT]) begin
			r = {ctl[63:43], {5{va[47]}}, va[47:13], 3'h0};
		end else begin
			r = {ctl[63:33], va[42:13], 3'h0};
		end
		return r;
	endfunction

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			data_address_control_ff     <= RST_ZERO;
			instruction_unit_control_ff <= RST_ZERO;
			process_context_ff          <= RST_ZERO;
		end else if (wr_req.valid) begin
			if (wr_req.index == IDX_D_CTL) begin
				data_address_control_ff <= wr_req.data & CTL_MASK;
			end
			if (wr_req.index == IDX_INSTRUCTION_UNIT_CONTROL) begin
				instruction_unit_control_ff <= wr_req.data & CTL_MASK;
			end
			if (wr_req.index == IDX_PROCESS_CONTEXT_REGISTER) begin
				process_context_ff <= wr_req.data & PROCESS_CONTEXT_REGISTER_MASK;
			end
		end
	end

	// Enable and mode fields written separately or together
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ier_ff <= '0;
			cm_ff  <= CM_KERNEL;
		end else if (wr_interrupt_enable_and_mode) begin
			if (wr_req.index[WR_IER_BIT]) begin
				ier_ff <= wr_req.data[IER_HI:IER_LO];
			end
			if (wr_req.index[WR_CM_BIT]) begin
				cm_ff <= wr_req.data[CM_HI:CM_LO];
			end
		end
	end

	// Cache flushes come only from their own registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flush_all_ff <= 1'b0;
			flush_ng_ff  <= 1'b0;
		end else begin
			flush_all_ff <= wr_req.valid && wr_req.index == IDX_FLUSH_ALL;
			flush_ng_ff  <= wr_req.valid && wr_req.index == IDX_FLUSH_NG;
		end
	end

	// ****************************************
	// Captured addresses
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			faulting_data_address_ff <= RST_ZERO;
		end else if (dfault_valid) begin
			faulting_data_address_ff <= dfault_addr;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			exception_return_address_ff <= RST_ZERO;
		end else if (exc_valid) begin
			if (exc_is_interrupt) begin
				exception_return_address_ff <=
					{exc_next_pc[63:2], 1'b0, exc_in_firmware};
			end else begin
				exception_return_address_ff <=
					{exc_fault_pc[63:2], 1'b0, exc_in_firmware};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			profiled_instruction_pc_ff <= RST_ZERO;
		end else if (prof_valid) begin
			profiled_instruction_pc_ff <= {prof_pc[63:2], 1'b0, prof_in_firmware};
		end
	end

	// Sign extension checker for the memory pipe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			chk_violation_ff <= 1'b0;
		end else if (!chk_valid) begin
			chk_violation_ff <= 1'b0;
		end else if (data_address_control_ff[CTL_WIDE_BIT]) begin
			chk_violation_ff <= chk_addr != {{16{chk_addr[47]}}, chk_addr[47:0]};
		end else begin
			chk_violation_ff <= chk_addr != {{21{chk_addr[42]}}, chk_addr[42:0]};
		end
	end

	// ****************************************
	// Translation buffer
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tag_hold_ff <= '0;
		end else if (wr_tag) begin
			tag_hold_ff <= wr_req.data[VPN_HI:VPN_LO];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fill_ptr_ff <= '0;
		end else if (wr_entry) begin
			fill_ptr_ff <= fill_ptr_ff + 4'h1;
		end
	end

	always_comb begin
		fill_data.vpn          = tag_hold_ff;
		fill_data.space_number_field          = process_context_ff[ASN_HI:ASN_LO];
		fill_data.global_match = wr_req.data[PTE_GLB_BIT];
		fill_data.gh           = wr_req.data[PTE_GH_HI:PTE_GH_LO];
		fill_data.pfn          = wr_req.data[PTE_PFN_HI:PTE_PFN_LO];
	end

	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
			assign fill_vec[gi] = wr_entry && fill_ptr_ff == PTR_W'(gi);
			fcr_xlate_entry u_entry (
				.clk_sys    (clk_sys),
				.rst_b      (rst_b),
				.fill       (fill_vec[gi]),
				.fill_data  (fill_data),
				.inv_all    (wr_inv_all),
				.inv_proc   (wr_inv_proc),
				.inv_single (wr_inv_single),
				.inv_vpn    (wr_req.data[VPN_HI:VPN_LO]),
				.cur_asn    (process_context_ff[ASN_HI:ASN_LO]),
				.lk_vpn     (lk_vpn),
				.hit        (hit_vec[gi]),
				.contents   (contents_vec[gi])
			);
		end
	endgenerate

	// Lookup result, lowest matching entry wins
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lk_hit_ff <= 1'b0;
			lk_pfn_ff <= '0;
		end else begin
			lk_hit_ff <= |hit_vec;
			lk_pfn_ff <= '0;
			for (int i = ENTRIES - 1; i >= 0; i--) begin
				if (hit_vec[i]) begin
					lk_pfn_ff <= contents_vec[i].pfn;
				end
			end
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff <= RST_ZERO;
			rd_ack_ff  <= 1'b0;
		end else begin
			rd_ack_ff <= rd_req.valid;
			if (rd_req.valid) begin
				if (rd_req.index[7:2] == SEL_INTERRUPT_ENABLE_AND_MODE) begin
					rd_data_ff <= {25'h0, ier_ff, 8'h0, cm_ff, 3'h0};
				end else begin
					case (rd_req.index)
						IDX_D_ADDR:  rd_data_ff <= faulting_data_address_ff;
						IDX_D_FORM:  rd_data_ff <= fmt_pte_addr(data_address_control_ff,
							faulting_data_address_ff);
						IDX_I_FORM:  rd_data_ff <= fmt_pte_addr(instruction_unit_control_ff,
							exception_return_address_ff);
						IDX_EXCEPTION_RETURN_ADDRESS: rd_data_ff <= exception_return_address_ff;
						IDX_PROF_PC: rd_data_ff <= profiled_instruction_pc_ff;
						IDX_PROCESS_CONTEXT_REGISTER:    rd_data_ff <= process_context_ff;
						default:     rd_data_ff <= RST_ZERO;
					endcase
				end
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign async_trap_enables      = per_mode_trap_enables & {4{ier_ff[ASYNC_TRAP_GLOBAL_ENABLE_BIT-IER_LO]}};
	assign interrupt_enables       = ier_ff;
	assign current_privilege_field = cm_ff;
	assign big_endian_mode         = data_address_control_ff[CTL_BEND_BIT];
	assign icache_flush_all        = flush_all_ff;
	assign icache_flush_nonglobal  = flush_ng_ff;

endmodule

// ===== rtl/fcr_pkg.sv
/*
 * Shared constants and types of the fetch unit control register bank:
 * register indices, field positions, reset values and carrier structs.
 * Assumes an 8-bit register index and 64-bit register data on the
 * privileged register move port of the pipeline.
 */
package fcr_pkg;

	// ****************************************
	// Array geometry
	// ****************************************
	localparam int ENTRIES = 16;
	localparam int PTR_W   = 4;
	localparam int VPN_W   = 35;
	localparam int PFN_W   = 32;

	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [7:0] IDX_TAG_HOLD   = 8'h00;
	localparam logic [7:0] IDX_ENTRY_WR   = 8'h01;
	localparam logic [7:0] IDX_INV_PROC   = 8'h02;
	localparam logic [7:0] IDX_INV_ALL    = 8'h03;
	localparam logic [7:0] IDX_INV_SINGLE = 8'h04;
	localparam logic [7:0] IDX_PROF_PC    = 8'h05;
	localparam logic [7:0] IDX_EXCEPTION_RETURN_ADDRESS   = 8'h06;
	localparam logic [7:0] IDX_I_FORM     = 8'h07;
	localparam logic [5:0] SEL_INTERRUPT_ENABLE_AND_MODE     = 6'h02;
	localparam logic [7:0] IDX_INSTRUCTION_UNIT_CONTROL      = 8'h0c;
	localparam logic [7:0] IDX_PROCESS_CONTEXT_REGISTER       = 8'h0d;
	localparam logic [7:0] IDX_FLUSH_ALL  = 8'h0e;
	localparam logic [7:0] IDX_FLUSH_NG   = 8'h0f;
	localparam logic [7:0] IDX_D_ADDR     = 8'h10;
	localparam logic [7:0] IDX_D_FORM     = 8'h11;
	localparam logic [7:0] IDX_D_CTL      = 8'h12;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int VPN_HI      = 47;
	localparam int VPN_LO      = 13;
	localparam int ASN_HI      = 46;
	localparam int ASN_LO      = 39;
	localparam int PTE_PFN_HI  = 44;
	localparam int PTE_PFN_LO  = 13;
	localparam int PTE_GH_HI   = 6;
	localparam int PTE_GH_LO   = 5;
	localparam int PTE_GLB_BIT = 4;
	localparam int IER_HI      = 38;
	localparam int IER_LO      = 13;
	localparam int ASYNC_TRAP_GLOBAL_ENABLE_BIT   = 13;
	localparam int CM_HI       = 4;
	localparam int CM_LO       = 3;
	localparam int WR_IER_BIT  = 1;
	localparam int WR_CM_BIT   = 0;
	localparam int CTL_BASE_LO = 30;
	localparam int CTL_F32_BIT = 2;
	localparam int CTL_WIDE_BIT = 1;
	localparam int CTL_BEND_BIT = 0;

	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [63:0] CTL_MASK    = 64'hffff_ffff_c000_0007;
	localparam logic [63:0] PROCESS_CONTEXT_REGISTER_MASK   = 64'h0000_7f80_0000_0000;
	localparam logic [63:0] INTERRUPT_ENABLE_AND_MODE_MASK = 64'h0000_007f_ffff_e018;
	localparam logic [63:0] RST_ZERO    = 64'h0;
	localparam logic [1:0]  CM_KERNEL   = 2'h0;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic [7:0]  index;
		logic [63:0] data;
	} fcr_req_s;

	typedef struct packed {
		logic [VPN_W-1:0] vpn;
		logic [7:0]       space_number_field;
		logic             global_match;
		logic [1:0]       gh;
		logic [PFN_W-1:0] pfn;
	} fcr_entry_s;

endpackage

// ===== rtl/fcr_xlate_entry.sv
/*
 * One entry of the instruction translation buffer: valid bit plus tag and
 * page contents, with fill, the three invalidate forms and a lookup match.
 * Assumes at most one fill or invalidate command per cycle.
 */
`timescale 1ns/1ns
module fcr_xlate_entry
	import fcr_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic             fill,
	input  wire fcr_entry_s       fill_data,
	input  wire logic             inv_all,
	input  wire logic             inv_proc,
	input  wire logic             inv_single,
	input  wire logic [VPN_W-1:0] inv_vpn,
	input  wire logic [7:0]       cur_asn,
	input  wire logic [VPN_W-1:0] lk_vpn,
	output logic                  hit,
	output fcr_entry_s            contents
);

	logic             valid_ff;
	fcr_entry_s       entry_ff;
	logic [VPN_W-1:0] gh_mask;
	logic             inv_match;

	// Granularity hint drops 3 page bits per step
	always_comb begin
		case (entry_ff.gh)
			2'h0:    gh_mask = {VPN_W{1'b1}};
			2'h1:    gh_mask = ~35'h7;
			2'h2:    gh_mask = ~35'h3f;
			2'h3:    gh_mask = ~35'h1ff;
			default: gh_mask = {VPN_W{1'b1}};
		endcase
	end

	always_comb begin
		inv_match = (((entry_ff.vpn ^ inv_vpn) & gh_mask) == '0) &&
			(entry_ff.space_number_field == cur_asn);
		if (entry_ff.global_match && entry_ff.vpn == inv_vpn) begin
			inv_match = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			valid_ff <= 1'b0;
		end else if (fill) begin
			valid_ff <= 1'b1;
		end else if (inv_all) begin
			valid_ff <= 1'b0;
		end else if (inv_proc && !entry_ff.global_match) begin
			valid_ff <= 1'b0;
		end else if (inv_single && inv_match) begin
			valid_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			entry_ff <= '0;
		end else if (fill) begin
			entry_ff <= fill_data;
		end
	end

	assign hit      = valid_ff && (((entry_ff.vpn ^ lk_vpn) & gh_mask) == '0) &&
		(entry_ff.global_match || entry_ff.space_number_field == cur_asn);
	assign contents = entry_ff;

endmodule

// ===== dv/fcr_fetch_regs_asserts.sv
/* Port assertions of the fetch register bank.
   Bound to fcr_fetch_regs; one clock, async active-low reset. */
`timescale 1ns/1ns
module fcr_fetch_regs_asserts
	import fcr_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire fcr_req_s    wr_req,
	input wire fcr_req_s    rd_req,
	input wire logic [63:0] rd_data_ff,
	input wire logic        rd_ack_ff,
	input wire logic        chk_valid,
	input wire logic        chk_violation_ff,
	input wire logic [3:0]  per_mode_trap_enables,
	input wire logic [3:0]  async_trap_enables,
	input wire logic [25:0] interrupt_enables,
	input wire logic [1:0]  current_privilege_field,
	input wire logic        icache_flush_all,
	input wire logic        icache_flush_nonglobal
);
	logic sel_w;
	logic sel_r;

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	assign sel_w = wr_req.valid && (wr_req.index[7:2] == SEL_INTERRUPT_ENABLE_AND_MODE);
	assign sel_r = rd_req.valid && (rd_req.index[7:2] == SEL_INTERRUPT_ENABLE_AND_MODE) && !wr_req.valid;

	property p_ier_set;
		logic [25:0] v;
		(sel_w && wr_req.index[WR_IER_BIT], v = wr_req.data[38:13]) |=> interrupt_enables == v;
	endproperty
	property p_cm_set;
		logic [1:0] v;
		(sel_w && wr_req.index[WR_CM_BIT], v = wr_req.data[4:3]) |=> current_privilege_field == v;
	endproperty

	a_read_ack_next: assert property (rd_req.valid |=> rd_ack_ff)
		else $error("read not acknowledged next cycle");
	a_read_ack_idle: assert property (!rd_req.valid |=> !rd_ack_ff)
		else $error("acknowledge without read");
	a_read_data_hold: assert property (!rd_req.valid |=> $stable(rd_data_ff))
		else $error("read data changed without read");
	a_ier_field_write: assert property (p_ier_set)
		else $error("enable field not written");
	a_ier_field_keep: assert property (sel_w && !wr_req.index[WR_IER_BIT] |=> $stable(interrupt_enables))
		else $error("enable field written without its index bit");
	a_mode_field_write: assert property (p_cm_set)
		else $error("mode field not written");
	a_mode_field_keep: assert property (!(sel_w && wr_req.index[WR_CM_BIT]) |=> $stable(current_privilege_field))
		else $error("mode field changed without write");
	a_trap_gate_and: assert property (async_trap_enables == (per_mode_trap_enables & {4{interrupt_enables[0]}}))
		else $error("trap enable gating wrong");
	a_mode_read_both: assert property (sel_r |=> rd_data_ff == {25'h0, interrupt_enables, 8'h0, current_privilege_field, 3'h0})
		else $error("enable and mode read wrong");
	a_flush_all_only: assert property (!(wr_req.valid && wr_req.index == IDX_FLUSH_ALL) |=> !icache_flush_all)
		else $error("unrequested full cache flush");
	a_flush_all_pulse: assert property (wr_req.valid && wr_req.index == IDX_FLUSH_ALL |=> icache_flush_all)
		else $error("full cache flush missing");
	a_flush_ng_only: assert property (!(wr_req.valid && wr_req.index == IDX_FLUSH_NG) |=> !icache_flush_nonglobal)
		else $error("unrequested nonglobal cache flush");
	a_check_idle_zero: assert property (!chk_valid |=> !chk_violation_ff)
		else $error("violation without check");

	c_mode_write: cover property (sel_w && wr_req.index[1:0] == 2'h3);
	c_flush_all: cover property (icache_flush_all);
	c_violation: cover property (chk_violation_ff);
endmodule

bind fcr_fetch_regs fcr_fetch_regs_asserts fcr_fetch_regs_asserts_inst (.clk_sys, .rst_b,
	.wr_req, .rd_req, .rd_data_ff, .rd_ack_ff, .chk_valid, .chk_violation_ff,
	.per_mode_trap_enables, .async_trap_enables, .interrupt_enables,
	.current_privilege_field, .icache_flush_all, .icache_flush_nonglobal);

// ===== dv/fcr_pipe_model.sv
/* Pipeline model issuing privileged register moves.
   Requests start just after a rising edge; gap adds idle cycles. */
`timescale 1ns/1ns
module fcr_pipe_model
	import fcr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [63:0] rd_data_ff,
	input  wire logic        rd_ack_ff,
	output fcr_req_s         wr_req,
	output fcr_req_s         rd_req
);
	int gap = 0;

	initial begin
		wr_req = '0;
		rd_req = '0;
	end

	task automatic wr(input logic [7:0] idx, input logic [63:0] d);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		wr_req <= '{1'b1, idx, d};
		@(posedge clk_sys);
		wr_req <= '{1'b0, ~idx, ~d};
	endtask

	task automatic rd(input logic [7:0] idx, output logic [63:0] d, output logic ack);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		rd_req <= '{1'b1, idx, 64'h0};
		@(posedge clk_sys);
		rd_req <= '{1'b0, ~idx, 64'h0};
		#1;
		d = rd_data_ff;
		ack = rd_ack_ff;
	endtask
endmodule

// ===== dv/fcr_fetch_regs_tb.sv
/* Self-checking bench of the fetch register bank.
   Pipeline model issues register moves; events are driven here. */
`timescale 1ns/1ns
module fcr_fetch_regs_tb;
	import fcr_pkg::*;
	typedef struct packed {
		logic [7:0]  wi;
		logic [63:0] wd;
		logic [7:0]  ri;
		logic [63:0] ex;
	} fcr_row_s;

	logic             clk_sys = 1'b0;
	logic             rst_b = 1'b0;
	fcr_req_s         wr_req, rd_req;
	logic [63:0]      rd_data_ff, dfault_addr = '0, exc_fault_pc = '0, exc_next_pc = '0;
	logic [63:0]      prof_pc = '0, chk_addr = '0;
	logic             rd_ack_ff, chk_violation_ff, lk_hit_ff, big_endian_mode;
	logic             icache_flush_all, icache_flush_nonglobal;
	logic             dfault_valid = 1'b0, exc_valid = 1'b0, exc_is_interrupt = 1'b0;
	logic             exc_in_firmware = 1'b0, prof_valid = 1'b0, prof_in_firmware = 1'b0;
	logic             chk_valid = 1'b0;
	logic [VPN_W-1:0] lk_vpn = '0;
	logic [PFN_W-1:0] lk_pfn_ff;
	logic [3:0]       per_mode_trap_enables = 4'hb, async_trap_enables;
	logic [25:0]      interrupt_enables;
	logic [1:0]       current_privilege_field;
	int               n_tests = 0, err_count = 0;
	logic [63:0]      ctl [4] = '{64'hfedc_ba98_c000_0000, 64'hfedc_ba98_c000_0003,
		64'hfedc_ba98_c000_0004, 64'hfedc_ba98_c000_0007};
	fcr_row_s         rows [10] = '{
		'{8'h0b, '1, 8'h08, 64'h7f_ffff_e018}, '{8'h09, 64'h0, 8'h08, 64'h7f_ffff_e000},
		'{8'h0a, 64'h0, 8'h08, 64'h0}, '{8'h09, 64'h8, 8'h0a, 64'h8},
		'{8'h09, 64'h10, 8'h08, 64'h10}, '{8'h0b, 64'h18, 8'h08, 64'h18},
		'{8'h08, '1, 8'h0b, 64'h18}, '{8'h0a, 64'h2000, 8'h09, 64'h2018},
		'{8'h40, '1, 8'h40, 64'h0}, '{8'h0d, '1, 8'h0d, 64'h7f80_0000_0000}};

	always #10 clk_sys = ~clk_sys;

	fcr_pipe_model fcr_pipe_model_inst (.clk_sys, .rd_data_ff, .rd_ack_ff, .wr_req, .rd_req);
	fcr_fetch_regs fcr_fetch_regs_inst (.clk_sys, .rst_b, .wr_req, .rd_req, .rd_data_ff,
		.rd_ack_ff, .dfault_valid, .dfault_addr, .exc_valid, .exc_is_interrupt, .exc_fault_pc,
		.exc_next_pc, .exc_in_firmware, .prof_valid, .prof_pc, .prof_in_firmware, .chk_valid,
		.chk_addr, .chk_violation_ff, .lk_vpn, .lk_hit_ff, .lk_pfn_ff, .per_mode_trap_enables,
		.async_trap_enables, .interrupt_enables, .current_privilege_field, .big_endian_mode,
		.icache_flush_all, .icache_flush_nonglobal);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [63:0] form(input logic [63:0] c, input logic [63:0] v);
		if (c[2]) begin
			return {32'h0, c[31:30], 8'h0, v[31:13], 3'h0};
		end
		if (c[1]) begin
			return {c[63:43], {5{v[47]}}, v[47:13], 3'h0};
		end
		return {c[63:33], v[42:13], 3'h0};
	endfunction

	task automatic end_of_test();
		$display("comparisons=%0d mismatches=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [63:0] exp);
		logic [63:0] d;
		logic        a;
		fcr_pipe_model_inst.rd(idx, d, a);
		check({63'h0, a}, 64'h1);
		check(d, exp);
	endtask

	task automatic look(input logic [VPN_W-1:0] v, input logic [63:0] exp);
		@(posedge clk_sys);
		lk_vpn <= v;
		@(posedge clk_sys);
		#1;
		check({31'h0, lk_hit_ff, lk_pfn_ff}, exp);
	endtask

	task automatic exc(input logic intr, input logic [63:0] fpc, input logic [63:0] npc);
		@(posedge clk_sys);
		exc_valid <= 1'b1;
		exc_is_interrupt <= intr;
		exc_fault_pc <= fpc;
		exc_next_pc <= npc;
		exc_in_firmware <= ~intr;
		@(posedge clk_sys);
		exc_valid <= 1'b0;
	endtask

	initial begin
		#200000;
		err_count++;
		end_of_test();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd_chk(8'h08, 64'h0);
		foreach (rows[i]) begin
			fcr_pipe_model_inst.wr(rows[i].wi, rows[i].wd);
			rd_chk(rows[i].ri, rows[i].ex);
		end
		check({32'h0, async_trap_enables, interrupt_enables, current_privilege_field},
			64'hb000_0007);
		rd_chk(IDX_PROF_PC, 64'h0);
		fcr_pipe_model_inst.gap = 2;
		fcr_pipe_model_inst.wr(IDX_PROCESS_CONTEXT_REGISTER, 64'h0000_0080_0000_0000);
		for (int i = 0; i < 17; i++) begin
			fcr_pipe_model_inst.wr(IDX_TAG_HOLD, 64'(i == 16 ? 16 : i + 1) << 13);
			fcr_pipe_model_inst.wr(IDX_ENTRY_WR, (64'(i + 256) << 13) | (64'(i & 1) << 4));
		end
		fcr_pipe_model_inst.gap = 0;
		look(35'd1, 64'h0);
		look(35'd16, 64'h1_0000_0110);
		fcr_pipe_model_inst.wr(IDX_INV_SINGLE, 64'd3 << 13);
		look(35'd3, 64'h0);
		look(35'd4, 64'h1_0000_0103);
		fcr_pipe_model_inst.wr(IDX_PROCESS_CONTEXT_REGISTER, 64'h0000_0100_0000_0000);
		fcr_pipe_model_inst.wr(IDX_INV_SINGLE, 64'd4 << 13);
		fcr_pipe_model_inst.wr(IDX_INV_SINGLE, 64'd5 << 13);
		#1;
		check({62'h0, icache_flush_all, icache_flush_nonglobal}, 64'h0);
		fcr_pipe_model_inst.wr(IDX_PROCESS_CONTEXT_REGISTER, 64'h0000_0080_0000_0000);
		look(35'd4, 64'h0);
		look(35'd5, 64'h1_0000_0104);
		fcr_pipe_model_inst.wr(IDX_INV_PROC, 64'h0);
		look(35'd5, 64'h0);
		look(35'd6, 64'h1_0000_0105);
		fcr_pipe_model_inst.wr(IDX_FLUSH_NG, 64'h0);
		#1;
		check({62'h0, icache_flush_all, icache_flush_nonglobal}, 64'h1);
		fcr_pipe_model_inst.wr(IDX_INV_ALL, 64'h0);
		#1;
		check({62'h0, icache_flush_all, icache_flush_nonglobal}, 64'h0);
		look(35'd6, 64'h0);
		fcr_pipe_model_inst.wr(IDX_FLUSH_ALL, 64'h0);
		#1;
		check({62'h0, icache_flush_all, icache_flush_nonglobal}, 64'h2);
		fcr_pipe_model_inst.wr(IDX_TAG_HOLD, 64'd7 << 13);
		look(35'd7, 64'h0);
		fcr_pipe_model_inst.wr(IDX_ENTRY_WR, 64'h55 << 13);
		look(35'd7, 64'h1_0000_0055);
		exc(1'b0, 64'hffff_8000_1234_567b, 64'h4444);
		rd_chk(IDX_EXCEPTION_RETURN_ADDRESS, 64'hffff_8000_1234_5679);
		@(posedge clk_sys);
		dfault_valid <= 1'b1;
		dfault_addr <= 64'hffff_9abc_def0_1234;
		prof_valid <= 1'b1;
		prof_pc <= 64'h0000_1111_2222_3337;
		prof_in_firmware <= 1'b1;
		@(posedge clk_sys);
		dfault_valid <= 1'b0;
		prof_valid <= 1'b0;
		rd_chk(IDX_D_ADDR, 64'hffff_9abc_def0_1234);
		rd_chk(IDX_PROF_PC, 64'h0000_1111_2222_3335);
		foreach (ctl[i]) begin
			fcr_pipe_model_inst.wr(IDX_INSTRUCTION_UNIT_CONTROL, ctl[i]);
			rd_chk(IDX_I_FORM, form(ctl[i], 64'hffff_8000_1234_5679));
			fcr_pipe_model_inst.wr(IDX_D_CTL, ctl[i]);
			#1;
			check({63'h0, big_endian_mode}, {63'h0, ctl[i][0]});
			rd_chk(IDX_D_FORM, form(ctl[i], 64'hffff_9abc_def0_1234));
			@(posedge clk_sys);
			chk_valid <= 1'b1;
			chk_addr <= 64'h0000_0400_0000_0000;
			@(posedge clk_sys);
			chk_valid <= 1'b0;
			#1;
			check({63'h0, chk_violation_ff}, {63'h0, ~ctl[i][1]});
		end
		exc(1'b1, 64'h4444, 64'h0000_0000_0000_8006);
		rd_chk(IDX_EXCEPTION_RETURN_ADDRESS, 64'h8004);
		end_of_test();
	end
endmodule
